// *** inc/pdh_cfg.svh ***
// Purpose: Constants for the powered-device hotswap controller
// Assumes: 125 MHz system clock
// Notes:   Times are kept in printed units, cycle counts derived here
`ifndef PDH_CFG_SVH
`define PDH_CFG_SVH

`define PDH_CLK_MHZ    125
`define PDH_DWELL_MS   80
`define PDH_QUAL_US    140
`define PDH_DWELL_CYC  (`PDH_DWELL_MS * 1000 * `PDH_CLK_MHZ)
`define PDH_QUAL_CYC   (`PDH_QUAL_US * `PDH_CLK_MHZ)
`define PDH_DWELL_W    24
`define PDH_QUAL_W     15
`define PDH_GRANT_IDLE 1'h1

`endif

// *** inc/pdh_pkg.sv ***
// Purpose: Types for the powered-device hotswap controller
// Assumes: Nothing beyond the cfg header
// Notes:   Comparator bits are active high
package pdh_pkg;

  typedef enum logic [1:0] {
    PDH_SW_OFF,
    PDH_SW_INRUSH,
    PDH_SW_ON,
    PDH_SW_OVERLOAD
  } pdh_sw_state_t;

  typedef enum logic [2:0] {
    PDH_CT_IDLE,
    PDH_CT_CLASS1,
    PDH_CT_MARK1,
    PDH_CT_CLASS2,
    PDH_CT_MARK2
  } pdh_class_state_t;

  // Analog comparator and strap levels
  typedef struct packed {
    logic undervoltage_lockout;
    logic sw_below_on;
    logic sw_above_ovl;
    logic sw_above_off;
    logic line_in_det_window;
    logic line_above_class;
    logic line_below_mark;
    logic line_above_surge;
    logic below_keepalive;
    logic auto_sleep_en;
  } pdh_cmp_t;

  // Drive of the input power switch
  typedef struct packed {
    logic conduct;
    logic cur_limit;
    logic low_limit;
    logic node_isolate;
  } pdh_sw_drive_t;

endpackage

// *** rtl/pdh_hotswap_fsm.sv ***
// Purpose: Hotswap switch sequencer and classification tracker of a PD
// Assumes: Comparator levels arrive asynchronously from the analog front
// Notes:   Dwell and qualification counts are parameters for simulation
`timescale 1ns/100ps
`include "pdh_cfg.svh"

module pdh_hotswap_fsm
  import pdh_pkg::*;
#(
  parameter logic [`PDH_DWELL_W-1:0] DWELL_CYC = `PDH_DWELL_W'(`PDH_DWELL_CYC),
  parameter logic [`PDH_QUAL_W-1:0]  QUAL_CYC  = `PDH_QUAL_W'(`PDH_QUAL_CYC)
) (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          rst_i,
  // Analog comparators
  input  wire pdh_cmp_t      cmp_i,
  // External switch gate pin
  input  wire logic          external_switch_gate_i,
  output logic               external_switch_gate_o,
  output logic               external_switch_gate_oe_o,
  // Switch drive and status
  output pdh_sw_drive_t      sw_drive_o,
  output pdh_sw_state_t      sw_state_o,
  // Line side
  output logic               det_sig_valid_o,
  output logic               surge_prot_o,
  output logic               keepalive_req_o,
  output logic               high_power_grant_n_o
);

  ////////////////////////////////////////////////////////////////////
  // Synchroniser
  pdh_cmp_t cmp_meta_ff;
  pdh_cmp_t cmp_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_meta_ff <= '{undervoltage_lockout: 1'h1, default: 1'h0};
      cmp_ff      <= '{undervoltage_lockout: 1'h1, default: 1'h0};
    end else begin
      cmp_meta_ff <= cmp_i;
      cmp_ff      <= cmp_meta_ff;
    end
  end

  // Lockout is seen as active until the synchroniser has filled
  logic lockout;
  logic lockout_prev_ff;
  logic lockout_rise;

  assign lockout      = cmp_ff.undervoltage_lockout;
  assign lockout_rise = lockout && !lockout_prev_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lockout_prev_ff <= 1'h1;
    end else begin
      lockout_prev_ff <= lockout;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // External gate strap
  logic strap_done_ff;
  logic ext_use_ff;

  // A grounded pin reads low; a FET gate lets the weak pull-up win
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_done_ff <= 1'h0;
      ext_use_ff    <= 1'h0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'h1;
      ext_use_ff    <= external_switch_gate_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Classification tracker
  pdh_class_state_t ct_state_ff;
  pdh_class_state_t nxt_ct_state;

  always_comb begin
    nxt_ct_state = ct_state_ff;
    if (lockout_rise) begin
      nxt_ct_state = PDH_CT_IDLE;
    end else if (lockout) begin
      unique case (ct_state_ff)
        PDH_CT_IDLE: begin
          if (cmp_ff.line_above_class) begin
            nxt_ct_state = PDH_CT_CLASS1;
          end
        end
        PDH_CT_CLASS1: begin
          if (cmp_ff.line_below_mark) begin
            nxt_ct_state = PDH_CT_MARK1;
          end
        end
        PDH_CT_MARK1: begin
          if (cmp_ff.line_above_class) begin
            nxt_ct_state = PDH_CT_CLASS2;
          end
        end
        PDH_CT_CLASS2: begin
          if (cmp_ff.line_below_mark) begin
            nxt_ct_state = PDH_CT_MARK2;
          end
        end
        PDH_CT_MARK2: begin
          nxt_ct_state = PDH_CT_MARK2;
        end
        default: begin
          nxt_ct_state = PDH_CT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ct_state_ff <= PDH_CT_IDLE;
    end else begin
      ct_state_ff <= nxt_ct_state;
    end
  end

  logic two_event;
  logic sw_enable;

  assign two_event = (ct_state_ff == PDH_CT_MARK2);
  assign sw_enable = !lockout && (ct_state_ff != PDH_CT_IDLE);

  ////////////////////////////////////////////////////////////////////
  // Dwell and qualification timers
  pdh_sw_state_t           state_ff;
  pdh_sw_state_t           nxt_state;
  logic [`PDH_DWELL_W-1:0] dwell_ff;
  logic [`PDH_QUAL_W-1:0]  qual_ff;
  logic                    dwell_done;
  logic                    qual_done;

  assign dwell_done = (dwell_ff >= DWELL_CYC - `PDH_DWELL_W'(1));
  assign qual_done  = cmp_ff.sw_above_ovl && (qual_ff >= QUAL_CYC - `PDH_QUAL_W'(1));

  // Saturating so a long dwell cannot wrap back below the limit
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dwell_ff <= '0;
    end else if (lockout || nxt_state != state_ff) begin
      dwell_ff <= '0;
    end else if (!dwell_done) begin
      dwell_ff <= dwell_ff + `PDH_DWELL_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      qual_ff <= '0;
    end else if (lockout || state_ff != PDH_SW_ON || !cmp_ff.sw_above_ovl) begin
      qual_ff <= '0;
    end else if (!qual_done) begin
      qual_ff <= qual_ff + `PDH_QUAL_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Switch state machine
  always_comb begin
    nxt_state = state_ff;
    if (lockout) begin
      nxt_state = PDH_SW_OFF;
    end else if (cmp_ff.sw_above_off) begin
      nxt_state = PDH_SW_OFF;
    end else begin
      unique case (state_ff)
        PDH_SW_OFF: begin
          if (sw_enable) begin
            nxt_state = PDH_SW_INRUSH;
          end
        end
        PDH_SW_INRUSH: begin
          if (cmp_ff.sw_below_on && (!two_event || dwell_done)) begin
            nxt_state = PDH_SW_ON;
          end
        end
        PDH_SW_ON: begin
          if (qual_done) begin
            nxt_state = PDH_SW_OVERLOAD;
          end
        end
        PDH_SW_OVERLOAD: begin
          if (cmp_ff.sw_below_on && dwell_done) begin
            nxt_state = PDH_SW_ON;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= PDH_SW_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Switch drive and gate, registered from the next state so drive matches state
  pdh_sw_drive_t sw_drive_ff;
  logic          ext_gate_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_drive_ff <= '{conduct: 1'h0, cur_limit: 1'h0, low_limit: 1'h0, node_isolate: 1'h1};
      ext_gate_ff <= 1'h0;
    end else begin
      sw_drive_ff.conduct      <= (nxt_state == PDH_SW_ON);
      sw_drive_ff.cur_limit    <= (nxt_state == PDH_SW_INRUSH);
      sw_drive_ff.low_limit    <= (nxt_state == PDH_SW_OVERLOAD);
      sw_drive_ff.node_isolate <= (nxt_state == PDH_SW_OFF);
      ext_gate_ff              <= ext_use_ff && (nxt_state == PDH_SW_ON);
    end
  end

  logic det_valid_ff;
  logic surge_ff;
  logic keepalive_ff;
  logic grant_n_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      det_valid_ff <= 1'h0;
    end else begin
      det_valid_ff <= cmp_ff.line_in_det_window && (nxt_ct_state != PDH_CT_MARK1)
                      && (state_ff == PDH_SW_OFF);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      surge_ff <= 1'h0;
    end else begin
      surge_ff <= cmp_ff.line_above_surge && (state_ff == PDH_SW_OFF);
    end
  end

  // Switch must be on and conducting for the current test to mean anything
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      keepalive_ff <= 1'h0;
    end else begin
      keepalive_ff <= (state_ff == PDH_SW_ON) && cmp_ff.below_keepalive
                      && cmp_ff.auto_sleep_en;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      grant_n_ff <= `PDH_GRANT_IDLE;
    end else begin
      grant_n_ff <= !(nxt_ct_state == PDH_CT_MARK2);
    end
  end

  assign sw_drive_o                = sw_drive_ff;
  assign sw_state_o                = state_ff;
  assign external_switch_gate_o    = ext_gate_ff;
  assign external_switch_gate_oe_o = ext_use_ff;
  assign det_sig_valid_o           = det_valid_ff;
  assign surge_prot_o              = surge_ff;
  assign keepalive_req_o           = keepalive_ff;
  assign high_power_grant_n_o      = grant_n_ff;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  lockout_holds_off_a: assert property (
    lockout |=> (state_ff == PDH_SW_OFF) && sw_drive_o.node_isolate
  ) else $error("switch not off under lockout");
  enable_to_inrush_a: assert property (
    (state_ff == PDH_SW_OFF) && sw_enable && !cmp_ff.sw_above_off
    |=> (state_ff == PDH_SW_INRUSH) && sw_drive_o.cur_limit
  ) else $error("enable did not start inrush");
  single_event_on_a: assert property (
    (state_ff == PDH_SW_INRUSH) && !lockout && !cmp_ff.sw_above_off
    && cmp_ff.sw_below_on && !two_event |=> state_ff == PDH_SW_ON
  ) else $error("single-event inrush did not go on");
  two_event_dwell_a: assert property (
    (state_ff == PDH_SW_INRUSH) && two_event ##1 (state_ff == PDH_SW_ON)
    |-> $past(dwell_ff) >= DWELL_CYC - `PDH_DWELL_W'(1)
  ) else $error("two-event inrush left early");
  overload_qualify_a: assert property (
    $rose(state_ff == PDH_SW_OVERLOAD)
    |-> $past(qual_ff) == QUAL_CYC - `PDH_QUAL_W'(1) && $past(cmp_ff.sw_above_ovl)
  ) else $error("overload entered without full qualification");
  overload_return_a: assert property (
    (state_ff == PDH_SW_OVERLOAD) ##1 (state_ff == PDH_SW_ON)
    |-> $past(cmp_ff.sw_below_on) && $past(dwell_done)
  ) else $error("overload returned too soon");
  switch_off_a: assert property (
    cmp_ff.sw_above_off |=> (state_ff == PDH_SW_OFF) && !sw_drive_o.conduct
  ) else $error("switch not opened above off threshold");
  grant_low_a: assert property (
    !high_power_grant_n_o |-> two_event
  ) else $error("grant low without full sequence");
  surge_gate_a: assert property (
    surge_prot_o |-> $past(cmp_ff.line_above_surge) && $past(state_ff == PDH_SW_OFF)
  ) else $error("surge protection while switch on");
  tracker_clear_a: assert property (
    lockout_rise |=> (ct_state_ff == PDH_CT_IDLE) && dwell_ff == '0
  ) else $error("lockout did not clear tracker");

endmodule

// *** verification/pdh_pse_model.sv ***
// Purpose: Line-side model of the sourcing equipment
// Assumes: Phase codes come from the bench, one per test step
// Notes:   Only comparator levels are modelled, not real voltages
`timescale 1ns/100ps

module pdh_pse_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Phase: 0 idle, 1 detect, 2 class, 3 mark, 4 power
  input  wire logic [2:0] phase_i,
  // Line comparator levels
  output logic            in_det_o,
  output logic            above_class_o,
  output logic            below_mark_o
);
  logic detected_ff = 1'b0;

  // Rising edge, so a phase set by the bench at the falling edge is never raced
  always_ff @(posedge sys_clk_i) begin
    if (phase_i == 3'h1) begin
      detected_ff <= 1'b1;
    end else if (phase_i == 3'h0) begin
      detected_ff <= 1'b0;
    end
  end

  // Mark level sits inside the detection range, so the device must refuse it; det_sig_valid_o is held low in the first mark only
  always_comb begin
    in_det_o      = (phase_i == 3'h1) || (phase_i == 3'h3);
    above_class_o = detected_ff && ((phase_i == 3'h2) || (phase_i == 3'h4));
    below_mark_o  = (phase_i <= 3'h1) || (phase_i == 3'h3);
  end
endmodule

// *** verification/tb_pdh_hotswap_fsm.sv ***
// Purpose: Self-checking bench for the hotswap sequencer
// Assumes: Short dwell and qualification counts
// Notes:   Line levels other than line_above_surge come from the sourcing-side model
`timescale 1ns/100ps
`include "pdh_cfg.svh"

module tb_pdh_hotswap_fsm;
  import pdh_pkg::*;
  localparam int DW = 50;
  localparam int QC = 20;
  typedef struct packed {
    logic lko; logic [2:0] ph; logic bon, sur, bka, slp;
    pdh_sw_state_t st; logic det, sur_o, ka_o, gn, gate;
  } pdh_row_t;

  logic          clk = 1'b0;
  logic          rst_i = 1'b1;
  logic          strap = 1'b1;
  logic [2:0]    ph = 3'h0;
  pdh_cmp_t      cmp_drv = '0;
  pdh_cmp_t      cmp;
  logic          p_det, p_cls, p_mrk;
  logic          gate_o, gate_oe, det_o, sur_o, ka_o, gn_o;
  pdh_sw_drive_t drv;
  pdh_sw_state_t st;
  int            n_mismatch = 0;
  int            n_checks = 0;
  int            cyc = 0;
  pdh_row_t      rows [8];

  always #4 clk = ~clk;

  always_comb begin
    cmp = cmp_drv;
    cmp.line_in_det_window = p_det;
    cmp.line_above_class = p_cls;
    cmp.line_below_mark = p_mrk;
  end

  pdh_pse_model pdh_pse_model_inst (
    .sys_clk_i     (clk),
    .phase_i       (ph),
    .in_det_o      (p_det),
    .above_class_o (p_cls),
    .below_mark_o  (p_mrk)
  );

  pdh_hotswap_fsm #(
    .DWELL_CYC(`PDH_DWELL_W'(DW)),
    .QUAL_CYC (`PDH_QUAL_W'(QC))
  ) pdh_hotswap_fsm_inst (
    .sys_clk_i                 (clk),
    .rst_i                     (rst_i),
    .cmp_i                     (cmp),
    .external_switch_gate_i    (strap),
    .external_switch_gate_o    (gate_o),
    .external_switch_gate_oe_o (gate_oe),
    .sw_drive_o                (drv),
    .sw_state_o                (st),
    .det_sig_valid_o           (det_o),
    .surge_prot_o              (sur_o),
    .keepalive_req_o           (ka_o),
    .high_power_grant_n_o      (gn_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chk_st(input pdh_sw_state_t exp);
    n_checks++;
    if (st !== exp) begin
      n_mismatch++;
      $display("MISMATCH sw_state expected %0d seen %0d", exp, st);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // A hang in a bounded wait ends here rather than running forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{1'b1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, PDH_SW_OFF, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    rows[1] = '{1'b1, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0, PDH_SW_OFF, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    rows[2] = '{1'b1, 3'h2, 1'b0, 1'b0, 1'b0, 1'b0, PDH_SW_OFF, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    rows[3] = '{1'b0, 3'h4, 1'b0, 1'b0, 1'b0, 1'b0, PDH_SW_INRUSH, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    rows[4] = '{1'b0, 3'h4, 1'b1, 1'b0, 1'b0, 1'b0, PDH_SW_ON, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    rows[5] = '{1'b0, 3'h4, 1'b1, 1'b1, 1'b0, 1'b0, PDH_SW_ON, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    rows[6] = '{1'b0, 3'h4, 1'b1, 1'b0, 1'b1, 1'b1, PDH_SW_ON, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    rows[7] = '{1'b0, 3'h4, 1'b1, 1'b0, 1'b1, 1'b0, PDH_SW_ON, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    step(1);
    chk_st(PDH_SW_OFF);
    chk_bit("sw_drive", 1'b1, drv == 4'h1);
    chk_bit("grant_n", 1'b1, gn_o);
    step(2);
    rst_i = 1'b0;
    step(3);
    chk_bit("gate_oe", 1'b1, gate_oe);
    foreach (rows[i]) begin
      cmp_drv.undervoltage_lockout = rows[i].lko;
      ph = rows[i].ph;
      cmp_drv.sw_below_on = rows[i].bon;
      cmp_drv.line_above_surge = rows[i].sur;
      cmp_drv.below_keepalive = rows[i].bka;
      cmp_drv.auto_sleep_en = rows[i].slp;
      step(6);
      chk_st(rows[i].st);
      chk_bit("det_sig_valid", rows[i].det, det_o);
      chk_bit("surge_prot", rows[i].sur_o, sur_o);
      chk_bit("keepalive", rows[i].ka_o, ka_o);
      chk_bit("grant_n", rows[i].gn, gn_o);
      chk_bit("gate_o", rows[i].gate, gate_o);
      chk_bit("cur_limit", rows[i].st == PDH_SW_INRUSH, drv.cur_limit);
      chk_bit("conduct", rows[i].st == PDH_SW_ON, drv.conduct);
    end
    // Overload needs an unbroken run; a short burst must not count
    cmp_drv.sw_above_ovl = 1'b1;
    step(QC - 2);
    cmp_drv.sw_above_ovl = 1'b0;
    step(6);
    chk_st(PDH_SW_ON);
    cmp_drv.sw_above_ovl = 1'b1;
    step(QC + 8);
    chk_st(PDH_SW_OVERLOAD);
    chk_bit("low_limit", 1'b1, drv.low_limit);
    cmp_drv.sw_above_ovl = 1'b0;
    step(DW - 15);
    chk_st(PDH_SW_OVERLOAD);
    step(25);
    chk_st(PDH_SW_ON);
    cmp_drv.sw_above_off = 1'b1;
    step(5);
    chk_st(PDH_SW_OFF);
    chk_bit("node_isolate", 1'b1, drv.node_isolate);
    cmp_drv.sw_above_off = 1'b0;
    cmp_drv.undervoltage_lockout = 1'b1;
    ph = 3'h1;
    step(6);
    chk_st(PDH_SW_OFF);
    ph = 3'h2;
    step(6);
    ph = 3'h3;
    step(6);
    chk_bit("det_sig_valid", 1'b0, det_o);
    ph = 3'h2;
    step(6);
    chk_bit("grant_n", 1'b1, gn_o);
    ph = 3'h3;
    step(6);
    chk_bit("grant_n", 1'b0, gn_o);
    cmp_drv.undervoltage_lockout = 1'b0;
    ph = 3'h4;
    step(6);
    chk_st(PDH_SW_INRUSH);
    step(DW - 15);
    chk_st(PDH_SW_INRUSH);
    step(25);
    chk_st(PDH_SW_ON);
    cmp_drv.undervoltage_lockout = 1'b1;
    step(6);
    chk_st(PDH_SW_OFF);
    chk_bit("grant_n", 1'b1, gn_o);
    // Second reset with the gate pin strapped to ground
    strap = 1'b0;
    rst_i = 1'b1;
    cmp_drv = '0;
    ph = 3'h0;
    step(3);
    rst_i = 1'b0;
    step(10);
    chk_st(PDH_SW_OFF);
    chk_bit("gate_oe", 1'b0, gate_oe);
    give_verdict();
  end
endmodule
